// [adcot_pkg.sv]
// Purpose: Shared constants and types for the converter output timing block
// Assumes: core_clk at 125 MHz; strobe, sleep and sample code arrive from pins
// Notes:   All timing counts are derived from printed times here
package adcot_pkg;

  localparam int unsigned WORD_W      = 8;
  localparam int unsigned FIFO_DEPTH  = 16;
  localparam int unsigned LATENCY     = 3;
  localparam int unsigned CLK_MHZ     = 125;
  localparam int unsigned WAKE_NS     = 200;
  localparam int unsigned SLEEP_NS    = 200;
  // Least times round up to whole cycles
  localparam int unsigned WAKE_CYC    = (WAKE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SLEEP_CYC   = (SLEEP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W       = 8;

  localparam logic [WORD_W-1:0] CODE_ZERO    = 8'h00;
  localparam logic [WORD_W-1:0] CODE_MID_UP  = 8'h80;
  localparam logic [WORD_W-1:0] CODE_FULL    = 8'hFF;
  localparam logic [CNT_W-1:0]  WAKE_LOAD    = CNT_W'(WAKE_CYC);
  localparam logic [1:0]        FILL_PRIMED  = 2'(LATENCY);

  typedef enum logic [2:0] {
    ST_SLEEP = 3'b001,
    ST_WAKE  = 3'b010,
    ST_RUN   = 3'b100
  } adcot_state_e;

  // Pin inputs travelling together
  typedef struct packed {
    logic              strobe;
    logic              sleep_select;
    logic [WORD_W-1:0] analog_code;
  } adcot_pins_s;

  // Output pin group: data plus active-low enable and word valid flag
  typedef struct packed {
    logic [WORD_W-1:0] conversion_word;
    logic              conversion_word_oe_n;
    logic              word_valid;
  } adcot_out_s;

  typedef struct packed {
    adcot_pins_s       sync_m;
    adcot_pins_s       sync_s;
    logic              strobe_prev;
    adcot_state_e      st;
    logic [CNT_W-1:0]  wake_cnt;
    logic [1:0]        fill;
    logic [WORD_W-1:0] word;
    logic              valid;
  } adcot_core_s;

endpackage

// [adcot_fifo.sv]
// Purpose: Parameterised word FIFO with valid/ready on both sides
// Assumes: Single clock; flush empties it in one cycle
// Notes:   Full and empty are exact; in_ready low while full
`timescale 1ns/1ps
`default_nettype none
module adcot_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
  } adcot_fifo_s;

  adcot_fifo_s      s_q;
  adcot_fifo_s      s_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready  = (s_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_q.cnt != '0);
  assign out_data  = mem[s_q.rd];
  assign push      = in_valid && in_ready && !flush;
  assign pop       = out_valid && out_ready && !flush;

  always_comb
  begin
    s_d = s_q;
    if (flush)
    begin
      s_d = '0;
    end
    else
    begin
      if (push)
        s_d.wr = s_q.wr + 1'b1;
      if (pop)
        s_d.rd = s_q.rd + 1'b1;
      s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // Storage needs no reset; read only where counted valid
  always_ff @(posedge core_clk)
  begin
    if (push)
      mem[s_q.wr] <= in_data;
  end

endmodule
`default_nettype wire

// [adcot_core.sv]
// Purpose: Sampling, three-strobe latency and sleep behaviour of an 8-bit converter
// Assumes: Strobe, sleep and code are asynchronous pins, synchronised here
// Notes:   Sample history sits in a 16-word FIFO primed to three entries
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Each rising strobe edge freezes the present input code and starts converting it.
// - The output word changes only on rising strobe edges and is one 8-bit word.
// - The word for a sample appears three strobe edges after that sample was taken.
// - While sleep is high conversion stops and the output word is released to high impedance.
// - Output coding is straight binary, all zeros at bottom, all ones at top, 80h just above midscale.
module adcot_core (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 reset_n,
  // Pins from capture side
  input  wire adcot_pkg::adcot_pins_s pins,
  // Output pins
  output var  adcot_pkg::adcot_out_s  outs
);
  adcot_pkg::adcot_core_s       s_q;
  adcot_pkg::adcot_core_s       s_d;
  logic                         edge_seen;
  logic                         running;
  logic                         push_ok;
  logic                         fifo_in_ready;
  logic                         fifo_out_valid;
  logic                         pop_now;
  logic [adcot_pkg::WORD_W-1:0] fifo_out_data;

  assign edge_seen = s_q.sync_s.strobe && !s_q.strobe_prev;
  assign running   = (s_q.st == adcot_pkg::ST_RUN);
  // Back-pressure: no ready, no sample taken
  assign push_ok   = edge_seen && running && fifo_in_ready;
  assign pop_now   = push_ok && (s_q.fill == adcot_pkg::FILL_PRIMED);

  adcot_fifo #(
    .WIDTH (adcot_pkg::WORD_W),
    .DEPTH (adcot_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .flush     (!running),
    .in_valid  (push_ok),
    .in_ready  (fifo_in_ready),
    .in_data   (s_q.sync_s.analog_code),
    .out_valid (fifo_out_valid),
    .out_ready (pop_now),
    .out_data  (fifo_out_data)
  );

  always_comb
  begin
    s_d = s_q;
    // First stage feeds only the second
    s_d.sync_m      = pins;
    s_d.sync_s      = s_q.sync_m;
    s_d.strobe_prev = s_q.sync_s.strobe;
    case (s_q.st)
      adcot_pkg::ST_SLEEP:
      begin
        s_d.valid = 1'b0;
        s_d.fill  = 2'd0;
        if (!s_q.sync_s.sleep_select)
        begin
          s_d.st       = adcot_pkg::ST_WAKE;
          s_d.wake_cnt = adcot_pkg::WAKE_LOAD;
        end
      end
      adcot_pkg::ST_WAKE:
      begin
        // Strobes ignored until the power-up time has passed
        if (s_q.sync_s.sleep_select)
          s_d.st = adcot_pkg::ST_SLEEP;
        else if (s_q.wake_cnt <= 8'h01)
          s_d.st = adcot_pkg::ST_RUN;
        else
          s_d.wake_cnt = s_q.wake_cnt - 8'h01;
      end
      adcot_pkg::ST_RUN:
      begin
        if (s_q.sync_s.sleep_select)
        begin
          s_d.st    = adcot_pkg::ST_SLEEP;
          s_d.valid = 1'b0;
        end
        else if (push_ok)
        begin
          if (pop_now && fifo_out_valid)
          begin
            s_d.word  = fifo_out_data;
            s_d.valid = 1'b1;
          end
          else
            s_d.fill = s_q.fill + 2'd1;
        end
      end
      default:
      begin
        s_d.st = adcot_pkg::ST_SLEEP;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_q       <= '0;
      s_q.st    <= adcot_pkg::ST_SLEEP;
      // Sleep sync starts asleep, so a held pin is not missed
      s_q.sync_m.sleep_select <= 1'b1;
      s_q.sync_s.sleep_select <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign outs.conversion_word      = s_q.word;
  assign outs.conversion_word_oe_n = !running;
  assign outs.word_valid           = s_q.valid && running;

  // Checking helpers: samples of the last three edges
  logic [adcot_pkg::WORD_W-1:0] hist1_q;
  logic [adcot_pkg::WORD_W-1:0] hist2_q;
  logic [adcot_pkg::WORD_W-1:0] hist3_q;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hist1_q <= 8'h00;
      hist2_q <= 8'h00;
      hist3_q <= 8'h00;
    end
    else if (push_ok)
    begin
      hist1_q <= s_q.sync_s.analog_code;
      hist2_q <= hist1_q;
      hist3_q <= hist2_q;
    end
  end

  sequence s_primed_edge;
    push_ok && !s_q.sync_s.sleep_select && (s_q.fill == adcot_pkg::FILL_PRIMED);
  endsequence

  sequence s_sleep_seen;
    s_q.sync_s.sleep_select && running;
  endsequence

  property p_edge_takes_sample;
    @(posedge core_clk) disable iff (!reset_n)
    (edge_seen && running && !s_q.sync_s.sleep_select && s_q.fill < adcot_pkg::FILL_PRIMED)
      |=> (s_q.fill == $past(s_q.fill) + 2'd1);
  endproperty
  a_edge_takes_sample: assert property (p_edge_takes_sample) else $error("strobe edge did not take a sample");

  property p_word_moves_on_edge;
    @(posedge core_clk) disable iff (!reset_n)
    !$stable(s_q.word) |-> $past(edge_seen);
  endproperty
  a_word_moves_on_edge: assert property (p_word_moves_on_edge) else $error("word changed without strobe edge");

  property p_three_strobe_latency;
    @(posedge core_clk) disable iff (!reset_n)
    s_primed_edge |=> (s_q.word == $past(hist3_q)) && s_q.valid;
  endproperty
  a_three_strobe_latency: assert property (p_three_strobe_latency) else $error("word not from third edge back");

  property p_sleep_releases;
    @(posedge core_clk) disable iff (!reset_n)
    s_sleep_seen |=> outs.conversion_word_oe_n && !outs.word_valid;
  endproperty
  a_sleep_releases: assert property (p_sleep_releases) else $error("outputs driven during sleep");

  property p_wake_holds_off;
    @(posedge core_clk) disable iff (!reset_n)
    ($past(s_q.st) == adcot_pkg::ST_SLEEP && s_q.st == adcot_pkg::ST_WAKE)
      |-> outs.conversion_word_oe_n [*8];
  endproperty
  a_wake_holds_off: assert property (p_wake_holds_off) else $error("outputs driven too soon after wake");

  property p_no_valid_before_prime;
    @(posedge core_clk) disable iff (!reset_n)
    (running && s_q.fill < adcot_pkg::FILL_PRIMED) |-> !s_q.valid;
  endproperty
  a_no_valid_before_prime: assert property (p_no_valid_before_prime) else $error("valid before three strobes");

  // Cycles spent in the power-up wait, for the wake check
  logic [adcot_pkg::CNT_W-1:0] wake_len_q;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      wake_len_q <= 8'h00;
    else if (s_q.st == adcot_pkg::ST_WAKE)
      wake_len_q <= wake_len_q + 8'h01;
    else
      wake_len_q <= 8'h00;
  end

  sequence s_wake_ends;
    ($past(s_q.st) == adcot_pkg::ST_WAKE) && (s_q.st == adcot_pkg::ST_RUN);
  endsequence

  property p_wake_full_time;
    @(posedge core_clk) disable iff (!reset_n)
    s_wake_ends |-> (wake_len_q >= adcot_pkg::WAKE_LOAD);
  endproperty
  a_wake_full_time: assert property (p_wake_full_time) else $error("run entered before power-up time");

  property p_sleep_flushes;
    @(posedge core_clk) disable iff (!reset_n)
    (s_q.st == adcot_pkg::ST_SLEEP) |=> !fifo_out_valid && (s_q.fill == 2'd0);
  endproperty
  a_sleep_flushes: assert property (p_sleep_flushes) else $error("history kept through sleep");

  property p_word_held_off;
    @(posedge core_clk) disable iff (!reset_n)
    !running |=> $stable(s_q.word);
  endproperty
  a_word_held_off: assert property (p_word_held_off) else $error("word changed while not converting");

endmodule
`default_nettype wire

// [adcot_cap_model.sv]
// Purpose: Capture-side model: makes strobe, sleep and code, latches words
// Assumes: Strobe 8 high, 8 low core_clk cycles, about 7.8 MSPS
// Notes:   Code only changes mid-low so it is steady around each rise
`timescale 1ns/1ps
`default_nettype none
module adcot_cap_model (
  // Clock
  input  wire logic                   core_clk,
  // Controls from bench
  input  wire logic                   run,
  input  wire logic                   sleep_req,
  // Pins
  output var  adcot_pkg::adcot_pins_s pins,
  input  wire adcot_pkg::adcot_out_s  outs
);
  // Bottom, top and both sides of midscale
  localparam logic [7:0] CODES [8] = '{8'h00, 8'hFF, 8'h80, 8'h7F, 8'h01, 8'hFE, 8'h55, 8'hAA};
  logic [3:0] phase = 4'h0;
  logic [2:0] idx   = 3'h0;
  logic [7:0] sent_q [$];
  logic [7:0] got_q  [$];

  initial pins = '0;
  always @(negedge core_clk)
  begin
    pins.sleep_select <= sleep_req;
    pins.analog_code  <= CODES[idx];
    // A burst always ends a whole strobe period
    if (run || phase != 4'h0)
    begin
      if (phase == 4'h0)
      begin
        pins.strobe <= 1'b1;
        sent_q.push_back(CODES[idx]);
      end
      // Latch half a period after the rise, word settled by then
      if (phase == 4'h8)
      begin
        pins.strobe <= 1'b0;
        if (outs.word_valid === 1'b1 && outs.conversion_word_oe_n === 1'b0)
          got_q.push_back(outs.conversion_word);
      end
      if (phase == 4'hC)
        idx <= idx + 3'h1;
      phase <= phase + 4'h1;
    end
  end
endmodule
`default_nettype wire

// [tb.sv]
// Purpose: Self-checking bench for the converter output timing core
// Assumes: Capture model makes all pin activity
// Notes:   Words are paired with samples by order of arrival
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                   core_clk  = 1'b0;
  logic                   reset_n   = 1'b0;
  logic                   run       = 1'b0;
  logic                   sleep_req = 1'b1;
  int                     err_total = 0;
  int                     tests_run = 0;
  adcot_pkg::adcot_pins_s pins;
  adcot_pkg::adcot_out_s  outs;
  // Released pins float
  wire logic [7:0]        word_pin = outs.conversion_word_oe_n ? 8'hZZ : outs.conversion_word;

  always #4 core_clk = ~core_clk;

  adcot_core DUT (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .pins     (pins),
    .outs     (outs)
  );

  adcot_cap_model u_cap (
    .core_clk  (core_clk),
    .run       (run),
    .sleep_req (sleep_req),
    .pins      (pins),
    .outs      (outs)
  );

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic burst(input int n);
    run <= 1'b1;
    repeat (16 * n - 8) @(negedge core_clk);
    run <= 1'b0;
    repeat (12) @(negedge core_clk);
  endtask

  task automatic test_latency();
    u_cap.sent_q.delete();
    u_cap.got_q.delete();
    burst(10);
    check(8'(u_cap.got_q.size()), 8'h07, "word count");
    for (int i = 0; i < 7; i++)
      check(u_cap.got_q[i], u_cap.sent_q[i], "word");
    $display("test latency done");
  endtask

  task automatic test_sleep();
    int n;
    run <= 1'b1;
    repeat (40) @(negedge core_clk);
    sleep_req <= 1'b1;
    repeat (adcot_pkg::SLEEP_CYC) @(negedge core_clk);
    check(word_pin, 8'hZZ, "pins released");
    check({7'h00, outs.word_valid}, 8'h00, "valid in sleep");
    n = u_cap.got_q.size();
    repeat (48) @(negedge core_clk);
    check(8'(u_cap.got_q.size() - n), 8'h00, "words in sleep");
    run <= 1'b0;
    repeat (20) @(negedge core_clk);
    $display("test sleep done");
  endtask

  task automatic test_wake();
    u_cap.sent_q.delete();
    u_cap.got_q.delete();
    sleep_req <= 1'b0;
    repeat (adcot_pkg::WAKE_CYC + 12) @(negedge core_clk);
    check({7'h00, outs.conversion_word_oe_n}, 8'h00, "driving after wake");
    check({7'h00, outs.word_valid}, 8'h00, "valid before strobes");
    burst(5);
    check(8'(u_cap.got_q.size()), 8'h02, "words after wake");
    check(u_cap.got_q[0], u_cap.sent_q[0], "first word");
    check(u_cap.got_q[1], u_cap.sent_q[1], "second word");
    $display("test wake done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(negedge core_clk);
    reset_n   <= 1'b1;
    sleep_req <= 1'b0;
    repeat (adcot_pkg::WAKE_CYC + 15) @(negedge core_clk);
    test_latency();
    test_sleep();
    test_wake();
    tally_and_finish();
  end

  // Tests need well under 1000 cycles
  initial
  begin
    repeat (4000) @(posedge core_clk);
    err_total++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
